//--- hw/pwm_trig_pkg.sv
// Shared constants for the PWM trigger and interrupt block.
package pwm_trig_pkg;

    // ----------------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------------
    localparam int NUM_GEN    = 4;
    localparam int TB_WIDTH   = 13;
    localparam int DATA_WIDTH = 16;
    localparam int ADDR_WIDTH = 8;
    localparam int PS_WIDTH   = 4;
    localparam int DIV_WIDTH  = 3;

    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [ADDR_WIDTH-1:0] ADDR_PT_CONTROL = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PT_PERIOD  = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] ADDR_SE_COMPARE = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] ADDR_PT_COUNTER = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] GEN_BASE        = 8'h20;
    localparam logic [ADDR_WIDTH-1:0] GEN_STRIDE      = 8'h20;
    localparam logic [ADDR_WIDTH-1:0] GEN_OFS_PERIOD  = 8'h00;
    localparam logic [ADDR_WIDTH-1:0] GEN_OFS_MATCH   = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] GEN_OFS_CONTROL = 8'h08;
    localparam logic [ADDR_WIDTH-1:0] GEN_OFS_TRIGCON = 8'h0C;
    localparam logic [ADDR_WIDTH-1:0] GEN_OFS_COUNTER = 8'h10;

    // ----------------------------------------------------------------
    // Field positions and reset values
    // ----------------------------------------------------------------
    localparam int PTC_RUN_BIT   = 0;
    localparam int PTC_SEIRQ_BIT = 1;
    localparam int PTC_PS_LSB    = 8;
    localparam int GC_RUN_BIT    = 0;
    localparam int GC_TRGIE_BIT  = 1;
    localparam int TC_DIV_LSB    = 0;
    localparam logic [TB_WIDTH-1:0]   PERIOD_RESET = 13'h1FFF;
    localparam logic [TB_WIDTH-1:0]   VALUE_RESET  = 13'h0000;
    localparam logic [DATA_WIDTH-1:0] READ_ZERO    = 16'h0000;

endpackage : pwm_trig_pkg

//--- hw/event_divider_if.sv
// Connection between an event source and its event divider.
`timescale 1ns/1ps
`default_nettype none
interface event_divider_if;
    import pwm_trig_pkg::*;
    logic                event_in;
    logic                clear;
    logic [PS_WIDTH-1:0] ratio;
    logic                pulse;
    modport owner   (output event_in, output clear, output ratio, input pulse);
    modport divider (input event_in, input clear, input ratio, output pulse);
endinterface : event_divider_if
`default_nettype wire

//--- hw/event_divider.sv
// Event divider: one output pulse per ratio+1 input events.
`timescale 1ns/1ps
`default_nettype none
module event_divider
    import pwm_trig_pkg::*;
(
    // Clock and reset
    input wire logic       mclk,
    input wire logic       srst,
    // Events in, pulses out
    event_divider_if.divider div
);

    logic [PS_WIDTH-1:0] count;

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    // A clear drops an event that lands in the same cycle, so counting
    // always restarts from a known point after a compare update.
    always_ff @(posedge mclk)
    begin
        if (srst || div.clear)
        begin
            count     <= '0;
            div.pulse <= 1'b0;
        end
        else if (div.event_in)
        begin
            div.pulse <= (count == div.ratio);
            count     <= (count == div.ratio) ? '0 : PS_WIDTH'(count + 1'b1);
        end
        else
        begin
            div.pulse <= 1'b0;
        end
    end

endmodule : event_divider
`default_nettype wire

//--- hw/timebase_counter.sv
// Time-base counter that runs from zero up to its period and wraps.
`timescale 1ns/1ps
`default_nettype none
module timebase_counter
    import pwm_trig_pkg::*;
(
    // Clock and reset
    input  wire logic                mclk,
    input  wire logic                srst,
    // Control
    input  wire logic                run,
    input  wire logic [TB_WIDTH-1:0] period,
    // State
    output var  logic [TB_WIDTH-1:0] count
);

    // ----------------------------------------------------------------
    // Counting
    // ----------------------------------------------------------------
    // Stopping holds the count at zero so the next start begins a period.
    always_ff @(posedge mclk)
    begin
        if (srst || !run)
            count <= VALUE_RESET;
        else if (count >= period)
            count <= VALUE_RESET;
        else
            count <= TB_WIDTH'(count + 1'b1);
    end

endmodule : timebase_counter
`default_nettype wire

//--- hw/pwm_adc_trigger_and_irq.sv
// Special-event and per-generator ADC triggers with interrupt requests.
`timescale 1ns/1ps
`default_nettype none
module pwm_adc_trigger_and_irq
    import pwm_trig_pkg::*;
(
    // Clock and reset
    input  wire logic                  mclk,
    input  wire logic                  srst,
    // Register port
    input  wire logic [ADDR_WIDTH-1:0] addr,
    input  wire logic [DATA_WIDTH-1:0] wdata,
    input  wire logic                  wr,
    input  wire logic                  rd,
    output var  logic [DATA_WIDTH-1:0] rdata,
    // Current-limit and fault pins
    input  wire logic [NUM_GEN-1:0]    current_limit_pin,
    input  wire logic [NUM_GEN-1:0]    fault_pin,
    // ADC triggers
    output var  logic                  special_event_trigger,
    output var  logic [NUM_GEN-1:0]    gen_adc_trigger,
    // Interrupt requests
    output var  logic                  special_event_irq,
    output var  logic [NUM_GEN-1:0]    gen_irq
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [ADDR_WIDTH-1:0] gen_addr
    (
        input int                    g,
        input logic [ADDR_WIDTH-1:0] ofs
    );
        gen_addr = ADDR_WIDTH'(GEN_BASE + ADDR_WIDTH'(g) * GEN_STRIDE + ofs);
    endfunction : gen_addr

    function automatic logic match_hit
    (
        input logic                run,
        input logic [TB_WIDTH-1:0] count,
        input logic [TB_WIDTH-1:0] value
    );
        match_hit = run && (count == value);
    endfunction : match_hit

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic                primary_run;
    logic                special_event_irq_enable;
    logic [PS_WIDTH-1:0] special_event_postscale;
    logic [TB_WIDTH-1:0] primary_period;
    logic [TB_WIDTH-1:0] special_event_compare;
    logic [TB_WIDTH-1:0] primary_timebase_counter;

    logic [NUM_GEN-1:0]   gen_run;
    logic [NUM_GEN-1:0]   trigger_irq_enable;
    logic [DIV_WIDTH-1:0] trigger_divider         [NUM_GEN];
    logic [TB_WIDTH-1:0]  gen_period              [NUM_GEN];
    logic [TB_WIDTH-1:0]  generator_trigger_match [NUM_GEN];
    logic [TB_WIDTH-1:0]  gen_counter             [NUM_GEN];

    logic compare_write;
    assign compare_write = wr && (addr == ADDR_SE_COMPARE);

    // ----------------------------------------------------------------
    // Primary time-base control
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            primary_run              <= 1'b0;
            special_event_irq_enable <= 1'b0;
            special_event_postscale  <= '0;
        end
        else if (wr && (addr == ADDR_PT_CONTROL))
        begin
            primary_run              <= wdata[PTC_RUN_BIT];
            special_event_irq_enable <= wdata[PTC_SEIRQ_BIT];
            special_event_postscale  <= wdata[PTC_PS_LSB +: PS_WIDTH];
        end
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            primary_period <= PERIOD_RESET;
        else if (wr && (addr == ADDR_PT_PERIOD))
            primary_period <= wdata[TB_WIDTH-1:0];
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            special_event_compare <= VALUE_RESET;
        else if (compare_write)
            special_event_compare <= wdata[TB_WIDTH-1:0];
    end

    // ----------------------------------------------------------------
    // Generator registers
    // ----------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (srst)
            begin
                gen_run[g]            <= 1'b0;
                trigger_irq_enable[g] <= 1'b0;
            end
            else if (wr && (addr == gen_addr(g, GEN_OFS_CONTROL)))
            begin
                gen_run[g]            <= wdata[GC_RUN_BIT];
                trigger_irq_enable[g] <= wdata[GC_TRGIE_BIT];
            end
        end
    end

    always_ff @(posedge mclk)
    begin
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (srst)
                trigger_divider[g] <= '0;
            else if (wr && (addr == gen_addr(g, GEN_OFS_TRIGCON)))
                trigger_divider[g] <= wdata[TC_DIV_LSB +: DIV_WIDTH];
        end
    end

    always_ff @(posedge mclk)
    begin
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (srst)
                gen_period[g] <= PERIOD_RESET;
            else if (wr && (addr == gen_addr(g, GEN_OFS_PERIOD)))
                gen_period[g] <= wdata[TB_WIDTH-1:0];
        end
    end

    always_ff @(posedge mclk)
    begin
        for (int g = 0; g < NUM_GEN; g++)
        begin
            if (srst)
                generator_trigger_match[g] <= VALUE_RESET;
            else if (wr && (addr == gen_addr(g, GEN_OFS_MATCH)))
                generator_trigger_match[g] <= wdata[TB_WIDTH-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Read port
    // ----------------------------------------------------------------
    logic [DATA_WIDTH-1:0] next_rdata;

    always_comb
    begin
        next_rdata = READ_ZERO;
        unique case (addr)
            ADDR_PT_CONTROL:
            begin
                next_rdata[PTC_RUN_BIT]                = primary_run;
                next_rdata[PTC_SEIRQ_BIT]              = special_event_irq_enable;
                next_rdata[PTC_PS_LSB +: PS_WIDTH]     = special_event_postscale;
            end
            ADDR_PT_PERIOD:  next_rdata[TB_WIDTH-1:0] = primary_period;
            ADDR_SE_COMPARE: next_rdata[TB_WIDTH-1:0] = special_event_compare;
            ADDR_PT_COUNTER: next_rdata[TB_WIDTH-1:0] = primary_timebase_counter;
            default:
            begin
                for (int g = 0; g < NUM_GEN; g++)
                begin
                    if (addr == gen_addr(g, GEN_OFS_PERIOD))
                        next_rdata[TB_WIDTH-1:0] = gen_period[g];
                    if (addr == gen_addr(g, GEN_OFS_MATCH))
                        next_rdata[TB_WIDTH-1:0] = generator_trigger_match[g];
                    if (addr == gen_addr(g, GEN_OFS_CONTROL))
                    begin
                        next_rdata[GC_RUN_BIT]   = gen_run[g];
                        next_rdata[GC_TRGIE_BIT] = trigger_irq_enable[g];
                    end
                    if (addr == gen_addr(g, GEN_OFS_TRIGCON))
                        next_rdata[TC_DIV_LSB +: DIV_WIDTH] = trigger_divider[g];
                    if (addr == gen_addr(g, GEN_OFS_COUNTER))
                        next_rdata[TB_WIDTH-1:0] = gen_counter[g];
                end
            end
        endcase
    end

    // Read data stand only in the cycle after the read strobe.
    always_ff @(posedge mclk)
    begin
        if (srst || !rd)
            rdata <= READ_ZERO;
        else
            rdata <= next_rdata;
    end

    // ----------------------------------------------------------------
    // Time bases
    // ----------------------------------------------------------------
    timebase_counter u_primary_tb
    (
        .mclk   (mclk),
        .srst   (srst),
        .run    (primary_run),
        .period (primary_period),
        .count  (primary_timebase_counter)
    );

    for (genvar g = 0; g < NUM_GEN; g++)
    begin : gen_tb
        timebase_counter u_local_tb
        (
            .mclk   (mclk),
            .srst   (srst),
            .run    (gen_run[g]),
            .period (gen_period[g]),
            .count  (gen_counter[g])
        );
    end

    // ----------------------------------------------------------------
    // Special-event trigger
    // ----------------------------------------------------------------
    event_divider_if se_div ();

    assign se_div.event_in = match_hit(primary_run, primary_timebase_counter,
                                       special_event_compare);
    assign se_div.clear    = compare_write;
    assign se_div.ratio    = special_event_postscale;

    event_divider u_se_postscaler
    (
        .mclk (mclk),
        .srst (srst),
        .div  (se_div.divider)
    );

    // No enable term: the ADC side decides whether to use the pulse.
    assign special_event_trigger = se_div.pulse;

    // The request follows the postscaled event so it lines up with the trigger.
    always_ff @(posedge mclk)
    begin
        if (srst)
            special_event_irq <= 1'b0;
        else
            special_event_irq <= se_div.event_in && special_event_irq_enable
                                 && (se_div.clear == 1'b0)
                                 && (u_se_postscaler.count == special_event_postscale);
    end

    // ----------------------------------------------------------------
    // Pin synchronisers and event edges
    // ----------------------------------------------------------------
    logic [NUM_GEN-1:0] cl_meta;
    logic [NUM_GEN-1:0] cl_sync;
    logic [NUM_GEN-1:0] cl_last;
    logic [NUM_GEN-1:0] flt_meta;
    logic [NUM_GEN-1:0] flt_sync;
    logic [NUM_GEN-1:0] flt_last;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            cl_meta  <= '0;
            cl_sync  <= '0;
            cl_last  <= '0;
            flt_meta <= '0;
            flt_sync <= '0;
            flt_last <= '0;
        end
        else
        begin
            cl_meta  <= current_limit_pin;
            cl_sync  <= cl_meta;
            cl_last  <= cl_sync;
            flt_meta <= fault_pin;
            flt_sync <= flt_meta;
            flt_last <= flt_sync;
        end
    end

    // ----------------------------------------------------------------
    // Generator triggers and interrupt requests
    // ----------------------------------------------------------------
    logic [NUM_GEN-1:0] gen_hit;

    for (genvar g = 0; g < NUM_GEN; g++)
    begin : gen_trig
        event_divider_if g_div ();

        // A match above the local period is never reached by the counter.
        assign gen_hit[g]     = match_hit(gen_run[g], gen_counter[g],
                                          generator_trigger_match[g]);
        assign g_div.event_in = gen_hit[g];
        assign g_div.clear    = 1'b0;
        assign g_div.ratio    = PS_WIDTH'(trigger_divider[g]);

        event_divider u_trig_div
        (
            .mclk (mclk),
            .srst (srst),
            .div  (g_div.divider)
        );

        assign gen_adc_trigger[g] = g_div.pulse;
    end

    // Pin events are counted on their rising edge only, so a held pin
    // requests once rather than every cycle.
    always_ff @(posedge mclk)
    begin
        if (srst)
            gen_irq <= '0;
        else
            gen_irq <= (gen_hit & trigger_irq_enable)
                       | (cl_sync & ~cl_last)
                       | (flt_sync & ~flt_last);
    end

endmodule : pwm_adc_trigger_and_irq
`default_nettype wire

//--- testbench/pwm_adc_trigger_and_irq_properties.sv
// Checker for the trigger and interrupt block, bound to its top module.
`timescale 1ns/1ps
`default_nettype none
module pwm_adc_trigger_and_irq_checker
    import pwm_trig_pkg::*;
(
    // Clock and reset
    input wire logic                  mclk,
    input wire logic                  srst,
    // Register port
    input wire logic [ADDR_WIDTH-1:0] addr,
    input wire logic [DATA_WIDTH-1:0] wdata,
    input wire logic                  wr,
    input wire logic                  rd,
    input wire logic [DATA_WIDTH-1:0] rdata,
    // Pins
    input wire logic [NUM_GEN-1:0]    current_limit_pin,
    input wire logic [NUM_GEN-1:0]    fault_pin,
    // Outputs
    input wire logic                  special_event_trigger,
    input wire logic [NUM_GEN-1:0]    gen_adc_trigger,
    input wire logic                  special_event_irq,
    input wire logic [NUM_GEN-1:0]    gen_irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    // ----------------------------------------------------------------
    // Shadow of the primary control bits
    // ----------------------------------------------------------------
    logic se_run;
    logic se_ie;

    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            se_run <= 1'b0;
            se_ie  <= 1'b0;
        end
        else if (wr && addr == ADDR_PT_CONTROL)
        begin
            se_run <= wdata[PTC_RUN_BIT];
            se_ie  <= wdata[PTC_SEIRQ_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    // A match one cycle before the enable changes may still pass, so both cycles are accepted.
    a_se_irq_enable: assert property (special_event_irq |-> se_ie || $past(se_ie))
        else $error("special event irq without enable");
    a_se_irq_follows: assert property (special_event_trigger && se_ie && $past(se_ie) |-> special_event_irq)
        else $error("special event irq missing");
    a_se_pulse_single: assert property (special_event_trigger |=> !special_event_trigger)
        else $error("special event trigger longer than one cycle");
    a_gen_pulse_single: assert property ((gen_adc_trigger & $past(gen_adc_trigger)) == 4'h0)
        else $error("generator trigger longer than one cycle");
    a_stopped_quiet: assert property (!se_run && !$past(se_run) |-> !special_event_trigger)
        else $error("special event trigger while primary base stopped");
    a_fault_irq: assert property ($rose(fault_pin[0]) |-> ##[1:4] gen_irq[0])
        else $error("fault edge gave no irq");
    a_limit_irq: assert property ($rose(current_limit_pin[1]) |-> ##[1:4] gen_irq[1])
        else $error("current limit edge gave no irq");
    a_counter_width: assert property (rd && addr == ADDR_PT_COUNTER |=> rdata[15:13] == 3'h0)
        else $error("counter wider than its field");
endmodule : pwm_adc_trigger_and_irq_checker

bind pwm_adc_trigger_and_irq pwm_adc_trigger_and_irq_checker checker_inst (
    .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .current_limit_pin(current_limit_pin), .fault_pin(fault_pin),
    .special_event_trigger(special_event_trigger), .gen_adc_trigger(gen_adc_trigger),
    .special_event_irq(special_event_irq), .gen_irq(gen_irq)
);
`default_nettype wire

//--- testbench/adc_irq_partner.sv
// Behavioural ADC sequencer and interrupt controller that tally incoming requests.
`timescale 1ns/1ps
`default_nettype none
module adc_irq_partner
    import pwm_trig_pkg::*;
(
    // Clock
    input  wire logic               mclk,
    // Requests, index 0 of the totals is the special event
    input  wire logic               special_event_trigger,
    input  wire logic [NUM_GEN-1:0] gen_adc_trigger,
    input  wire logic               special_event_irq,
    input  wire logic [NUM_GEN-1:0] gen_irq,
    output var  int                 trig_count [0:NUM_GEN],
    output var  int                 irq_count  [0:NUM_GEN]
);
    initial
    begin
        trig_count = '{default: 0};
        irq_count  = '{default: 0};
    end

    // Every high cycle is one request; an unknown level is never taken as one.
    always @(posedge mclk)
    begin
        trig_count[0] <= trig_count[0] + int'(special_event_trigger === 1'b1);
        irq_count[0]  <= irq_count[0] + int'(special_event_irq === 1'b1);
        for (int g = 0; g < NUM_GEN; g++)
        begin
            trig_count[g+1] <= trig_count[g+1] + int'(gen_adc_trigger[g] === 1'b1);
            irq_count[g+1]  <= irq_count[g+1] + int'(gen_irq[g] === 1'b1);
        end
    end
endmodule : adc_irq_partner
`default_nettype wire

//--- testbench/tb_pwm_adc_trigger_and_irq.sv
// Self-checking testbench of the trigger and interrupt block.
`timescale 1ns/1ps
`default_nettype none
module tb_pwm_adc_trigger_and_irq
    import pwm_trig_pkg::*;
;
    typedef struct {int unit; int period; int match; int ratio; int ie; int m; int exp_trig; int exp_irq;} row_type;

    logic                  mclk;
    logic                  srst;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic                  wr;
    logic                  rd;
    logic [DATA_WIDTH-1:0] rdata;
    logic [NUM_GEN-1:0]    current_limit_pin;
    logic [NUM_GEN-1:0]    fault_pin;
    logic                  special_event_trigger;
    logic [NUM_GEN-1:0]    gen_adc_trigger;
    logic                  special_event_irq;
    logic [NUM_GEN-1:0]    gen_irq;
    int                    trig_count [0:NUM_GEN];
    int                    irq_count  [0:NUM_GEN];
    int                    n_mismatch = 0;
    int                    n_tests    = 0;
    logic [DATA_WIDTH-1:0] got;
    int                    c0;

    // Unit 0 is the primary base, units 1 to 4 the generators; match 4 stays clear of the stop slack.
    row_type rows [0:7] = '{'{0, 9, 4, 0, 1, 4, 4, 4}, '{0, 9, 4, 3, 0, 8, 2, 0}, '{0, 5, 4, 15, 1, 32, 2, 2},
                           '{1, 9, 4, 0, 1, 4, 4, 4}, '{2, 7, 4, 6, 0, 14, 2, 0}, '{3, 5, 4, 2, 1, 6, 2, 6},
                           '{4, 9, 12, 0, 1, 4, 0, 0}, '{4, 9, 9, 1, 1, 4, 2, 4}};
    logic [ADDR_WIDTH-1:0] raddr [0:5] = '{ADDR_PT_PERIOD, GEN_BASE + GEN_OFS_PERIOD, ADDR_PT_CONTROL,
                                           ADDR_PT_COUNTER, GEN_BASE + GEN_OFS_MATCH, 8'hFC};
    logic [DATA_WIDTH-1:0] rexp [0:5] = '{{3'h0, PERIOD_RESET}, {3'h0, PERIOD_RESET}, READ_ZERO,
                                         READ_ZERO, {3'h0, VALUE_RESET}, READ_ZERO};

    pwm_adc_trigger_and_irq DUT (
        .mclk(mclk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
        .current_limit_pin(current_limit_pin), .fault_pin(fault_pin),
        .special_event_trigger(special_event_trigger), .gen_adc_trigger(gen_adc_trigger),
        .special_event_irq(special_event_irq), .gen_irq(gen_irq)
    );

    adc_irq_partner partner (
        .mclk(mclk), .special_event_trigger(special_event_trigger), .gen_adc_trigger(gen_adc_trigger),
        .special_event_irq(special_event_irq), .gen_irq(gen_irq), .trig_count(trig_count), .irq_count(irq_count)
    );

    always #4 mclk = ~mclk;

    // ----------------------------------------------------------------
    // Bus, wait and compare tasks
    // ----------------------------------------------------------------
    task idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle

    task wr_reg(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : wr_reg

    task rd_reg(input logic [ADDR_WIDTH-1:0] a, output logic [DATA_WIDTH-1:0] d);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task chk_cnt(input string name, input int exp, input int seen);
        n_tests++;
        if (exp != seen)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0d seen %0d", name, exp, seen);
        end
    endtask : chk_cnt

    task chk_data(input string name, input logic [DATA_WIDTH-1:0] exp, input logic [DATA_WIDTH-1:0] seen);
        n_tests++;
        if (exp !== seen)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk_data

    task report_and_stop;
        if (n_mismatch == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : report_and_stop

    // Runs one unit for m periods; the stop write lands two counts past the last period.
    task run_row(input row_type r);
        logic [ADDR_WIDTH-1:0] base;
        int                    t0;
        int                    i0;
        base = GEN_BASE + GEN_STRIDE * 8'(r.unit - 1);
        t0   = trig_count[r.unit];
        i0   = irq_count[r.unit];
        if (r.unit == 0)
        begin
            wr_reg(ADDR_PT_PERIOD, 16'(r.period));
            wr_reg(ADDR_SE_COMPARE, 16'(r.match));
            wr_reg(ADDR_PT_CONTROL, 16'((1 << PTC_RUN_BIT) | (r.ie << PTC_SEIRQ_BIT) | (r.ratio << PTC_PS_LSB)));
        end
        else
        begin
            wr_reg(base + GEN_OFS_PERIOD, 16'(r.period));
            wr_reg(base + GEN_OFS_MATCH, 16'(r.match));
            wr_reg(base + GEN_OFS_TRIGCON, 16'(r.ratio << TC_DIV_LSB));
            wr_reg(base + GEN_OFS_CONTROL, 16'((1 << GC_RUN_BIT) | (r.ie << GC_TRGIE_BIT)));
        end
        idle(r.m * (r.period + 1));
        wr_reg((r.unit == 0) ? ADDR_PT_CONTROL : base + GEN_OFS_CONTROL, 16'h0000);
        idle(4);
        chk_cnt("trigger count", r.exp_trig, trig_count[r.unit] - t0);
        chk_cnt("irq count", r.exp_irq, irq_count[r.unit] - i0);
    endtask : run_row

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial
    begin
        mclk              = 1'b0;
        srst              = 1'b1;
        addr              = 8'h00;
        wdata             = 16'h0000;
        wr                = 1'b0;
        rd                = 1'b0;
        current_limit_pin = 4'h0;
        fault_pin         = 4'h0;
        idle(4);
        srst <= 1'b0;
        for (int i = 0; i < 8; i++)
            run_row(rows[i]);
        // Rewriting the compare value between the first and second match drops the partial count.
        c0 = trig_count[0];
        wr_reg(ADDR_PT_PERIOD, 16'h0005);
        wr_reg(ADDR_SE_COMPARE, 16'h0004);
        wr_reg(ADDR_PT_CONTROL, 16'((1 << PTC_RUN_BIT) | (2 << PTC_PS_LSB)));
        idle(8);
        wr_reg(ADDR_SE_COMPARE, 16'h0004);
        idle(6);
        // Seventeen steps after the start the counter of period 5 stands at its top.
        rd_reg(ADDR_PT_COUNTER, got);
        chk_data("primary counter", 16'h0005, got);
        wr_reg(ADDR_PT_CONTROL, 16'h0000);
        idle(4);
        chk_cnt("postscale after clear", 0, trig_count[0] - c0);
        for (int g = 0; g < NUM_GEN; g++)
        begin
            c0 = irq_count[g+1];
            fault_pin[g] <= 1'b1;
            idle(6);
            current_limit_pin[g] <= 1'b1;
            idle(6);
            fault_pin[g]         <= 1'b0;
            current_limit_pin[g] <= 1'b0;
            idle(6);
            chk_cnt("pin irq count", 2, irq_count[g+1] - c0);
        end
        // A second reset restores the values; the unmapped place keeps nothing.
        srst <= 1'b1;
        idle(2);
        srst <= 1'b0;
        wr_reg(8'hFC, 16'hFFFF);
        for (int i = 0; i < 6; i++)
        begin
            rd_reg(raddr[i], got);
            chk_data("register read", rexp[i], got);
        end
        report_and_stop();
    end

    initial
    begin
        #100us;
        n_mismatch++;
        report_and_stop();
    end
endmodule : tb_pwm_adc_trigger_and_irq
`default_nettype wire
